// [src/pac_pkg.sv]
// Shared constants, types and helper functions for the pipeline abort and slotting control.
// How it works
// - Exceptions and interrupts drain every outstanding instruction before fetch restarts.
// - Aborts except arithmetic exceptions flush everything fetched after the aborting instruction.
// - Mispredicts and replays redirect fetch at once without waiting for a drain.
// - Non-arithmetic exceptions suppress younger register writes up to the write stage.
// - Arithmetic exceptions let younger work finish; address is after the last executed.
// - Machine check or interrupt: address is after the last executed instruction.
// - Any other exception: address is the faulting instruction itself.
// - After the drain, execution starts at the firmware dispatch address.
// - Drained means no register file writes pending and nothing still able to fault.
// - A missing resource aborts the instruction and fetch restarts exactly at it.
// - An operate issued against a load that then misses is aborted and replayed.
// - A data cache miss aborts or stalls issue depending on when it is seen.
// - Issue stalls when a register or function unit conflict blocks ready work.
// - Each predicted-taken branch, call or return inserts exactly one empty slot.
// - While stalled, a front-end stage advances when the stage ahead is empty.
// - Grouping affects only performance; results never depend on it.
// - Loads use either integer pipe; stores, barriers, flag ops use pipe zero.
// - Integer branches and jumps use integer pipe one; float branches the add pipe.
// - Add, logic, move, compare use either integer pipe; shifts, multiplies, misc pipe zero.
// - Float operate and divide use the add pipe, multiply its pipe, sign copy either.
// - Issued instructions never stall; only an abort stops them.
// - A load and a store are never slotted in the same group.
`default_nettype none
package pac_pkg;
  localparam int unsigned NSLOT  = 4;
  localparam int unsigned NPIPE  = 4;
  localparam int unsigned SLOT_W = 2;

  typedef logic [NPIPE-1:0] pac_pipe_t;
  typedef logic [NSLOT-1:0] pac_mask_t;

  localparam pac_pipe_t PIPE_NONE = 4'h0;
  localparam pac_pipe_t PIPE_E0   = 4'h1;
  localparam pac_pipe_t PIPE_E1   = 4'h2;
  localparam pac_pipe_t PIPE_FA   = 4'h4;
  localparam pac_pipe_t PIPE_FM   = 4'h8;
  localparam pac_pipe_t PIPE_INT  = 4'h3;
  localparam pac_pipe_t PIPE_FLT  = 4'hC;

  typedef enum logic [4:0] {
    CLS_LOAD = 5'h00, CLS_STORE = 5'h01, CLS_BARRIER = 5'h02, CLS_FLAG_RW = 5'h03,
    CLS_PREG_MOVE = 5'h04, CLS_INT_BRANCH = 5'h05, CLS_FLT_BRANCH = 5'h06, CLS_JUMP = 5'h07,
    CLS_INT_ADD = 5'h08, CLS_INT_LOGIC = 5'h09, CLS_SHIFT = 5'h0A, CLS_COND_MOVE = 5'h0B,
    CLS_INT_CMP = 5'h0C, CLS_MUL_LONG = 5'h0D, CLS_MUL_QUAD = 5'h0E, CLS_MUL_HIGH = 5'h0F,
    CLS_FLT_OP = 5'h10, CLS_FLT_DIV = 5'h11, CLS_FLT_PRODUCT = 5'h12, CLS_SIGN_COPY = 5'h13,
    CLS_MISC = 5'h14, CLS_NOP = 5'h15
  } pac_class_e;

  typedef enum logic [1:0] {
    EXC_ARITH    = 2'h0,
    EXC_MCHK_INT = 2'h1,
    EXC_OTHER    = 2'h2
  } pac_exc_e;

  typedef enum logic [2:0] {
    ST_RUN      = 3'h1,
    ST_DRAIN    = 3'h2,
    ST_DISPATCH = 3'h4
  } pac_state_e;

  // Pipes a class may use; a register move picks its pipe from the target register.
  function automatic pac_pipe_t pipe_mask(input pac_class_e c, input logic processor_register_move_class_e1);
    unique case (c)
      CLS_LOAD, CLS_INT_ADD, CLS_INT_LOGIC, CLS_COND_MOVE, CLS_INT_CMP: pipe_mask = PIPE_INT;
      CLS_STORE, CLS_BARRIER, CLS_FLAG_RW:                              pipe_mask = PIPE_E0;
      CLS_PREG_MOVE:                                 pipe_mask = processor_register_move_class_e1 ? PIPE_E1 : PIPE_E0;
      CLS_INT_BRANCH, CLS_JUMP:                                         pipe_mask = PIPE_E1;
      CLS_FLT_BRANCH, CLS_FLT_OP, CLS_FLT_DIV:                          pipe_mask = PIPE_FA;
      CLS_SHIFT, CLS_MUL_LONG, CLS_MUL_QUAD, CLS_MUL_HIGH, CLS_MISC:    pipe_mask = PIPE_E0;
      CLS_FLT_PRODUCT:                                                  pipe_mask = PIPE_FM;
      CLS_SIGN_COPY:                                                    pipe_mask = PIPE_FLT;
      default:                                                          pipe_mask = PIPE_NONE;
    endcase
  endfunction : pipe_mask

  function automatic logic is_branch(input pac_class_e c);
    is_branch = (c == CLS_INT_BRANCH) || (c == CLS_FLT_BRANCH) || (c == CLS_JUMP);
  endfunction : is_branch

  // Slots at or after the given one, optionally sparing the slot itself.
  function automatic pac_mask_t kill_from(input logic [SLOT_W-1:0] s, input logic incl);
    kill_from = '0;
    for (int i = 0; i < NSLOT; i++) begin
      if ((i > int'(s)) || (incl && (i == int'(s)))) begin
        kill_from[i] = 1'b1;
      end
    end
  endfunction : kill_from
endpackage : pac_pkg
`default_nettype wire

// [src/pac_slot_if.sv]
// Carrier between the abort controller and the slotting logic.
`timescale 1ns/1ns
`default_nettype none
interface pac_slot_if;
  logic                  valid     [pac_pkg::NSLOT];
  pac_pkg::pac_class_e   cls       [pac_pkg::NSLOT];
  logic                  processor_register_move_class_e1   [pac_pkg::NSLOT];
  logic                  pred_tkn  [pac_pkg::NSLOT];
  pac_pkg::pac_mask_t    take;
  pac_pkg::pac_pipe_t    pipe      [pac_pkg::NSLOT];
  logic                  taken_br;

  modport slot (input valid, cls, processor_register_move_class_e1, pred_tkn, output take, pipe, taken_br);
  modport ctl  (output valid, cls, processor_register_move_class_e1, pred_tkn, input take, pipe, taken_br);
endinterface : pac_slot_if
`default_nettype wire

// [src/pac_slotter.sv]
// In-order slotting of one fetched group onto the four execution pipes.
`timescale 1ns/1ns
`default_nettype none
module pac_slotter (
  pac_slot_if.slot sif
);
  // Grouping only changes throughput, never results, so stopping early is always safe.
  always_comb begin
    pac_pkg::pac_pipe_t used;
    pac_pkg::pac_pipe_t m;
    pac_pkg::pac_pipe_t pick;
    logic               stop;
    logic               have_ld;
    logic               have_st;
    logic               have_br;
    logic               next_e0;
    logic               seen;
    m            = pac_pkg::PIPE_NONE;
    pick         = pac_pkg::PIPE_NONE;
    next_e0      = 1'b0;
    seen         = 1'b0;
    used         = pac_pkg::PIPE_NONE;
    stop         = 1'b0;
    have_ld      = 1'b0;
    have_st      = 1'b0;
    have_br      = 1'b0;
    sif.take     = '0;
    sif.taken_br = 1'b0;
    for (int i = 0; i < pac_pkg::NSLOT; i++) begin
      sif.pipe[i] = pac_pkg::PIPE_NONE;
      m       = pac_pkg::pipe_mask(sif.cls[i], sif.processor_register_move_class_e1[i]);
      next_e0 = 1'b0;
      seen    = 1'b0;
      for (int j = i + 1; j < pac_pkg::NSLOT; j++) begin
        if (!seen && sif.valid[j] && (pac_pkg::pipe_mask(sif.cls[j], sif.processor_register_move_class_e1[j]) & pac_pkg::PIPE_FLT) == '0
            && sif.cls[j] != pac_pkg::CLS_NOP) begin
          seen    = 1'b1;
          next_e0 = pac_pkg::pipe_mask(sif.cls[j], sif.processor_register_move_class_e1[j]) == pac_pkg::PIPE_E0;
        end
      end
      pick = m & ~used;
      if (m == pac_pkg::PIPE_INT) begin
        pick = ((used & pac_pkg::PIPE_E0) != '0 || next_e0) && (used & pac_pkg::PIPE_E1) == '0
               ? pac_pkg::PIPE_E1 : pick & pac_pkg::PIPE_E0;
      end else if (m == pac_pkg::PIPE_FLT) begin
        pick = (used & pac_pkg::PIPE_FA) == '0 ? pac_pkg::PIPE_FA : pick & pac_pkg::PIPE_FM;
      end
      if (sif.valid[i] && !stop) begin
        if ((sif.cls[i] == pac_pkg::CLS_LOAD && have_st) || (sif.cls[i] == pac_pkg::CLS_STORE && have_ld)
            || (pac_pkg::is_branch(sif.cls[i]) && have_br)
            || (sif.cls[i] != pac_pkg::CLS_NOP && pick == pac_pkg::PIPE_NONE)) begin
          stop = 1'b1;
        end else begin
          sif.take[i] = 1'b1;
          sif.pipe[i] = pick;
          used        = used | pick;
          have_ld     = have_ld | (sif.cls[i] == pac_pkg::CLS_LOAD);
          have_st     = have_st | (sif.cls[i] == pac_pkg::CLS_STORE);
          have_br     = have_br | pac_pkg::is_branch(sif.cls[i]);
          if (pac_pkg::is_branch(sif.cls[i]) && sif.pred_tkn[i]) begin
            // Everything after a predicted-taken branch is discarded at slotting.
            sif.taken_br = 1'b1;
            stop         = 1'b1;
          end
        end
      end
    end
  end
endmodule : pac_slotter
`default_nettype wire

// [src/pac_exception_address_register.sv]
// Exception address register with the restart point chosen by exception kind.
`timescale 1ns/1ns
`default_nettype none
module pac_exception_address_register #(
  parameter int unsigned ADDR_W = 64
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_nrst,
  input  wire logic                i_capture,
  input  wire pac_pkg::pac_exc_e   i_kind,
  input  wire logic [ADDR_W-1:0]   i_fault_pc,
  input  wire logic [ADDR_W-1:0]   i_next_pc,
  output logic      [ADDR_W-1:0]   o_addr
);
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;

  always_comb begin
    addr_d = addr_q;
    if (i_capture) begin
      unique case (i_kind)
        pac_pkg::EXC_ARITH:    addr_d = i_next_pc;
        pac_pkg::EXC_MCHK_INT: addr_d = i_next_pc;
        default:               addr_d = i_fault_pc;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_q <= '0;
    end else begin
      addr_q <= addr_d;
    end
  end

  assign o_addr = addr_q;
endmodule : pac_exception_address_register
`default_nettype wire

// [src/pac_abort_ctl.sv]
// Abort, drain, redirect and issue-stall control for a four-wide in-order pipeline.
`timescale 1ns/1ns
`default_nettype none
module pac_abort_ctl #(
  parameter int unsigned ADDR_W = 64
) (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_nrst,
  // Fetched group arriving at the slotting stage.
  input  wire logic [pac_pkg::NSLOT-1:0]    i_grp_valid,
  input  wire pac_pkg::pac_class_e          i_grp_class    [pac_pkg::NSLOT],
  input  wire logic [pac_pkg::NSLOT-1:0]    i_grp_processor_register_move_class_e1,
  input  wire logic [pac_pkg::NSLOT-1:0]    i_grp_pred_tkn,
  // Dynamic conflicts seen at the issue check.
  input  wire logic                         i_reg_conflict,
  input  wire logic                         i_fu_conflict,
  input  wire logic [pac_pkg::NSLOT-1:0]    i_stage_occ,
  // Branch, call or return mispredict.
  input  wire logic                         i_mispredict,
  input  wire logic [pac_pkg::SLOT_W-1:0]   i_mispredict_slot,
  input  wire logic [ADDR_W-1:0]            i_mispredict_pc,
  // Resource unavailable after issue.
  input  wire logic                         i_rsrc_replay,
  input  wire logic [pac_pkg::SLOT_W-1:0]   i_rsrc_slot,
  input  wire logic [ADDR_W-1:0]            i_rsrc_pc,
  // Data cache miss and the operate that may have consumed the load.
  input  wire logic                         i_dc_miss,
  input  wire logic                         i_dc_use_issued,
  input  wire logic [pac_pkg::SLOT_W-1:0]   i_dc_use_slot,
  input  wire logic [ADDR_W-1:0]            i_dc_use_pc,
  // Exceptions, including interrupts and machine checks.
  input  wire logic                         i_exc,
  input  wire pac_pkg::pac_exc_e            i_exc_kind,
  input  wire logic [pac_pkg::SLOT_W-1:0]   i_exc_slot,
  input  wire logic [ADDR_W-1:0]            i_exc_fault_pc,
  input  wire logic [ADDR_W-1:0]            i_exc_next_pc,
  input  wire logic [ADDR_W-1:0]            i_fw_dispatch_pc,
  // Drain status from the execution pipes.
  input  wire logic                         i_int_rf_wr_pend,
  input  wire logic                         i_flt_rf_wr_pend,
  input  wire logic                         i_fault_pend,
  // Slotted group presented at the issue stage.
  output logic [pac_pkg::NSLOT-1:0]         o_slot_take,
  output pac_pkg::pac_pipe_t                o_slot_pipe    [pac_pkg::NSLOT],
  output logic                              o_issue_stall,
  output logic                              o_bubble,
  output logic [pac_pkg::NSLOT-1:0]         o_stage_adv,
  // Abort outputs.
  output logic [pac_pkg::NSLOT-1:0]         o_kill_mask,
  output logic                              o_flush,
  output logic                              o_wb_suppress,
  output logic                              o_fetch_hold,
  output logic                              o_draining,
  output logic                              o_redirect,
  output logic [ADDR_W-1:0]                 o_redirect_pc,
  output logic [ADDR_W-1:0]                 o_exception_address_register
);
  if (ADDR_W < 2) begin : g_bad_addr_w
    $error("pac_abort_ctl: ADDR_W must be at least 2");
  end

  pac_slot_if sif ();

  pac_slotter u_slotter (
    .sif (sif.slot)
  );

  for (genvar g = 0; g < pac_pkg::NSLOT; g++) begin : g_grp
    assign sif.valid[g]    = i_grp_valid[g];
    assign sif.cls[g]      = i_grp_class[g];
    assign sif.processor_register_move_class_e1[g]  = i_grp_processor_register_move_class_e1[g];
    assign sif.pred_tkn[g] = i_grp_pred_tkn[g];
  end

  pac_pkg::pac_state_e  state_q;
  pac_pkg::pac_state_e  state_d;
  logic [pac_pkg::NSLOT-1:0] take_q;
  logic [pac_pkg::NSLOT-1:0] take_d;
  pac_pkg::pac_pipe_t   pipe_q [pac_pkg::NSLOT];
  pac_pkg::pac_pipe_t   pipe_d [pac_pkg::NSLOT];
  logic                 tbr_q;
  logic                 tbr_d;
  logic                 bubble_q;
  logic                 bubble_d;
  logic [pac_pkg::NSLOT-1:0] kill_q;
  logic [pac_pkg::NSLOT-1:0] kill_d;
  logic                 flush_q;
  logic                 flush_d;
  logic                 supp_q;
  logic                 supp_d;
  logic                 redir_q;
  logic                 redir_d;
  logic [ADDR_W-1:0]    redir_pc_q;
  logic [ADDR_W-1:0]    redir_pc_d;
  logic                 exc_take;
  logic                 drained;
  logic                 dc_stall;
  logic                 stall;
  logic                 abort_now;

  // Another exception while draining is ignored; the first one owns the restart point.
  assign exc_take = i_exc && (state_q == pac_pkg::ST_RUN);

  // Only a machine check could still hit anything once these are all clear.
  assign drained = !i_int_rf_wr_pend && !i_flt_rf_wr_pend && !i_fault_pend;

  // A miss seen before any consumer issued only holds issue back.
  assign dc_stall = i_dc_miss && !i_dc_use_issued;

  // The stall is raised here, before issue, because nothing past issue can wait.
  assign stall = (take_q != '0) && (i_reg_conflict || i_fu_conflict || dc_stall);

  assign abort_now = exc_take || (state_q == pac_pkg::ST_RUN
                     && ((i_dc_miss && i_dc_use_issued) || i_rsrc_replay || i_mispredict));

  pac_exception_address_register #(
    .ADDR_W (ADDR_W)
  ) u_exception_address_register (
    .i_clk_sys  (i_clk_sys),
    .i_nrst     (i_nrst),
    .i_capture  (exc_take),
    .i_kind     (i_exc_kind),
    .i_fault_pc (i_exc_fault_pc),
    .i_next_pc  (i_exc_next_pc),
    .o_addr     (o_exception_address_register)
  );

  // Abort sequencing: exceptions first, then replays, then mispredicts.
  always_comb begin
    state_d    = state_q;
    kill_d     = '0;
    flush_d    = 1'b0;
    supp_d     = supp_q;
    redir_d    = 1'b0;
    redir_pc_d = redir_pc_q;
    unique case (state_q)
      pac_pkg::ST_RUN: begin
        if (i_exc) begin
          state_d = pac_pkg::ST_DRAIN;
          if (i_exc_kind != pac_pkg::EXC_ARITH) begin
            // The faulting slot and everything younger die; older members finish.
            kill_d  = pac_pkg::kill_from(i_exc_slot, 1'b1);
            flush_d = 1'b1;
            supp_d  = 1'b1;
          end
        end else if (i_dc_miss && i_dc_use_issued) begin
          redir_d    = 1'b1;
          redir_pc_d = i_dc_use_pc;
          kill_d     = pac_pkg::kill_from(i_dc_use_slot, 1'b1);
          flush_d    = 1'b1;
        end else if (i_rsrc_replay) begin
          redir_d    = 1'b1;
          redir_pc_d = i_rsrc_pc;
          kill_d     = pac_pkg::kill_from(i_rsrc_slot, 1'b1);
          flush_d    = 1'b1;
        end else if (i_mispredict) begin
          // The branch itself completes; only work fetched behind it is dropped.
          redir_d    = 1'b1;
          redir_pc_d = i_mispredict_pc;
          kill_d     = pac_pkg::kill_from(i_mispredict_slot, 1'b0);
          flush_d    = 1'b1;
        end
      end
      pac_pkg::ST_DRAIN: begin
        if (drained) begin
          state_d = pac_pkg::ST_DISPATCH;
        end
      end
      pac_pkg::ST_DISPATCH: begin
        redir_d    = 1'b1;
        redir_pc_d = i_fw_dispatch_pc;
        supp_d     = 1'b0;
        state_d    = pac_pkg::ST_RUN;
      end
    endcase
  end

  // Issue-stage group: held while stalled, cleared by any abort or while fetch is held.
  always_comb begin
    take_d   = take_q;
    tbr_d    = tbr_q;
    pipe_d   = pipe_q;
    bubble_d = 1'b0;
    if (abort_now || state_q != pac_pkg::ST_RUN) begin
      take_d = '0;
      tbr_d  = 1'b0;
      for (int i = 0; i < pac_pkg::NSLOT; i++) begin
        pipe_d[i] = pac_pkg::PIPE_NONE;
      end
    end else if (!stall) begin
      take_d   = sif.take;
      tbr_d    = sif.taken_br;
      pipe_d   = sif.pipe;
      // A taken branch leaves exactly one empty issue cycle behind it.
      bubble_d = tbr_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q    <= pac_pkg::ST_RUN;
      take_q     <= '0;
      tbr_q      <= 1'b0;
      bubble_q   <= 1'b0;
      kill_q     <= '0;
      flush_q    <= 1'b0;
      supp_q     <= 1'b0;
      redir_q    <= 1'b0;
      redir_pc_q <= '0;
      for (int i = 0; i < pac_pkg::NSLOT; i++) begin
        pipe_q[i] <= pac_pkg::PIPE_NONE;
      end
    end else begin
      state_q    <= state_d;
      take_q     <= take_d;
      tbr_q      <= tbr_d;
      bubble_q   <= bubble_d;
      kill_q     <= kill_d;
      flush_q    <= flush_d;
      supp_q     <= supp_d;
      redir_q    <= redir_d;
      redir_pc_q <= redir_pc_d;
      pipe_q     <= pipe_d;
    end
  end

  // Stage k may close up on a hole in stage k+1 even while issue is stuck.
  for (genvar g = 0; g < pac_pkg::NSLOT; g++) begin : g_adv
    if (g == pac_pkg::NSLOT - 1) begin : g_issue
      assign o_stage_adv[g] = !stall;
    end else begin : g_front
      assign o_stage_adv[g] = !stall || !i_stage_occ[g + 1];
    end
  end

  assign o_slot_take   = take_q;
  assign o_slot_pipe   = pipe_q;
  assign o_issue_stall = stall;
  assign o_bubble      = bubble_q;
  assign o_kill_mask   = kill_q;
  assign o_flush       = flush_q;
  assign o_wb_suppress = supp_q;
  assign o_fetch_hold  = state_q != pac_pkg::ST_RUN;
  assign o_draining    = state_q == pac_pkg::ST_DRAIN;
  assign o_redirect    = redir_q;
  assign o_redirect_pc = redir_pc_q;
endmodule : pac_abort_ctl
`default_nettype wire

// [testbench/pac_abort_ctl_asserts.sv]
// Concurrent checks on the abort, drain, dispatch and front-end advance outputs.
`timescale 1ns/1ns
`default_nettype none
module pac_abort_ctl_asserts #(
  parameter int unsigned ADDR_W = 64
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [pac_pkg::NSLOT-1:0] i_stage_occ,
  input wire logic i_exc,
  input wire pac_pkg::pac_exc_e i_exc_kind,
  input wire logic [pac_pkg::SLOT_W-1:0] i_exc_slot,
  input wire logic [ADDR_W-1:0] i_exc_fault_pc,
  input wire logic [ADDR_W-1:0] i_exc_next_pc,
  input wire logic [ADDR_W-1:0] i_fw_dispatch_pc,
  input wire logic i_int_rf_wr_pend,
  input wire logic i_flt_rf_wr_pend,
  input wire logic i_fault_pend,
  input wire logic o_issue_stall,
  input wire logic [pac_pkg::NSLOT-1:0] o_stage_adv,
  input wire logic [pac_pkg::NSLOT-1:0] o_kill_mask,
  input wire logic o_flush,
  input wire logic o_wb_suppress,
  input wire logic o_fetch_hold,
  input wire logic o_draining,
  input wire logic o_redirect,
  input wire logic [ADDR_W-1:0] o_redirect_pc,
  input wire logic [ADDR_W-1:0] o_exception_address_register
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  exc_kill_a: assert property (
    i_exc && !o_fetch_hold && i_exc_kind != pac_pkg::EXC_ARITH |=> o_draining && o_flush && o_wb_suppress
    && o_kill_mask == (4'hF << $past(i_exc_slot))) else $error("exception did not kill and drain");
  exception_address_register_a: assert property (
    i_exc && !o_fetch_hold |=> o_exception_address_register == (($past(i_exc_kind) == pac_pkg::EXC_OTHER)
    ? $past(i_exc_fault_pc) : $past(i_exc_next_pc))) else $error("wrong exception address");
  arith_keep_a: assert property (
    i_exc && !o_fetch_hold && i_exc_kind == pac_pkg::EXC_ARITH |=> o_kill_mask == 4'h0 && !o_flush
    && !o_wb_suppress) else $error("arithmetic exception killed work");
  drain_wait_a: assert property (
    o_draining && (i_int_rf_wr_pend || i_flt_rf_wr_pend || i_fault_pend) |=> o_draining)
    else $error("drain left with work pending");
  dispatch_a: assert property (
    o_draining && !(i_int_rf_wr_pend || i_flt_rf_wr_pend || i_fault_pend) |=> !o_draining && o_fetch_hold
    ##1 o_redirect && !o_fetch_hold && o_redirect_pc == $past(i_fw_dispatch_pc)) else $error("bad dispatch");
  no_early_a: assert property (o_draining |-> !o_redirect) else $error("redirect before drain");
  suppress_end_a: assert property ($fell(o_wb_suppress) |-> o_redirect) else $error("suppress dropped early");
  stage_adv_a: assert property (
    o_stage_adv == {!o_issue_stall, ~i_stage_occ[3:1] | {3{!o_issue_stall}}}) else $error("bad stage advance");
endmodule : pac_abort_ctl_asserts

bind pac_abort_ctl pac_abort_ctl_asserts #(.ADDR_W(ADDR_W)) i_pac_abort_ctl_asserts (.*);
`default_nettype wire

// [testbench/pac_pipe_model.sv]
// Execution pipes as seen by the drain logic: pending lines that clear a set lag into a drain.
`timescale 1ns/1ns
`default_nettype none
module pac_pipe_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_draining,
  input  wire logic [3:0] i_lag,
  output logic            o_int_pend,
  output logic            o_flt_pend,
  output logic            o_fault_pend
);
  logic [3:0] cnt_q;
  // Each line falls on its own cycle, so a drain that watches only the integer or the fault line ends too soon.
  assign o_int_pend   = i_draining && (cnt_q < i_lag);
  assign o_flt_pend   = i_draining && (cnt_q <= i_lag) && (i_lag != 4'h0);
  assign o_fault_pend = i_draining && (cnt_q < (i_lag >> 1));
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) cnt_q <= 4'h0;
    else cnt_q <= i_draining ? cnt_q + 4'h1 : 4'h0;
  end
endmodule : pac_pipe_model
`default_nettype wire

// [testbench/tb_pac_abort_ctl.sv]
// Self-checking bench for the abort, drain and slotting control.
`timescale 1ns/1ns
`default_nettype none
module tb_pac_abort_ctl;
  logic i_clk_sys = 1'b0;
  logic i_nrst, i_reg_conflict, i_fu_conflict, i_mispredict, i_rsrc_replay, i_dc_miss, i_dc_use_issued, i_exc;
  logic i_int_rf_wr_pend, i_flt_rf_wr_pend, i_fault_pend, o_issue_stall, o_bubble, o_flush, st;
  logic o_wb_suppress, o_fetch_hold, o_draining, o_redirect;
  logic [3:0] i_grp_valid, i_grp_processor_register_move_class_e1, i_grp_pred_tkn, i_stage_occ, o_slot_take, o_stage_adv, o_kill_mask, lag, al;
  logic [1:0] i_mispredict_slot, i_rsrc_slot, i_dc_use_slot, i_exc_slot;
  logic [63:0] i_mispredict_pc, i_rsrc_pc, i_dc_use_pc, i_exc_fault_pc, i_exc_next_pc, i_fw_dispatch_pc, pc;
  logic [63:0] o_redirect_pc, o_exception_address_register;
  pac_pkg::pac_class_e i_grp_class [4];
  pac_pkg::pac_pipe_t o_slot_pipe [4];
  pac_pkg::pac_exc_e i_exc_kind;
  int fails = 0, n_checks = 0, seed = 32'h4D42FC15, s;

  pac_abort_ctl i_pac_abort_ctl (.*);
  pac_pipe_model i_pac_pipe_model (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_draining(o_draining), .i_lag(lag),
    .o_int_pend(i_int_rf_wr_pend), .o_flt_pend(i_flt_rf_wr_pend), .o_fault_pend(i_fault_pend));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic complete_run();
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  function automatic logic [3:0] kmask(int s, logic incl);
    for (int i = 0; i < 4; i++) begin
      kmask[i] = (i > s) || (incl && i == s);
    end
  endfunction : kmask
  function automatic logic [3:0] allowed(int c, logic e1);
    case (c)
      0, 8, 9, 11, 12: allowed = 4'h3;
      1, 2, 3, 10, 13, 14, 15, 20: allowed = 4'h1;
      4: allowed = e1 ? 4'h2 : 4'h1;
      5, 7: allowed = 4'h2;
      6, 16, 17: allowed = 4'h4;
      18: allowed = 4'h8;
      19: allowed = 4'hC;
      default: allowed = 4'h0;
    endcase
  endfunction : allowed

  initial forever #5 i_clk_sys = ~i_clk_sys;
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  initial begin
    {i_nrst, i_reg_conflict, i_fu_conflict, i_mispredict, i_rsrc_replay, i_dc_miss, i_dc_use_issued, i_exc} = '0;
    {i_grp_valid, i_grp_processor_register_move_class_e1, i_grp_pred_tkn, i_stage_occ, lag, i_mispredict_slot, i_rsrc_slot} = '0;
    {i_dc_use_slot, i_exc_slot, i_mispredict_pc, i_rsrc_pc, i_dc_use_pc, i_exc_fault_pc} = '0;
    {i_exc_next_pc, i_fw_dispatch_pc} = '0;
    i_grp_class = '{default: pac_pkg::CLS_NOP};
    i_exc_kind = pac_pkg::EXC_ARITH;
    repeat (16) @(posedge i_clk_sys);
    #1 i_nrst = 1'b1;
    for (int c = 0; c < 22; c++) begin
      tick();
      i_grp_valid = 4'h1;
      i_grp_class[0] = pac_pkg::pac_class_e'(c);
      i_grp_processor_register_move_class_e1 = 4'($random(seed));
      al = allowed(c, i_grp_processor_register_move_class_e1[0]);
      tick();
      chk(o_slot_pipe[0] & ~al, 0);
      chk(|o_slot_pipe[0], |al);
      i_grp_valid = 4'h0;
    end
    tick();
    i_grp_valid = 4'h3;
    i_grp_class[0] = pac_pkg::CLS_LOAD;
    i_grp_class[1] = pac_pkg::CLS_STORE;
    tick();
    chk(o_slot_take, 4'h1);
    i_grp_valid = 4'h0;
    tick();
    i_grp_valid = 4'h3;
    i_grp_class[0] = pac_pkg::CLS_INT_BRANCH;
    i_grp_class[1] = pac_pkg::CLS_INT_ADD;
    i_grp_pred_tkn = 4'h1;
    tick();
    chk(o_slot_take, 4'h1);
    i_grp_valid = 4'h0;
    tick();
    chk(o_bubble, 1);
    tick();
    chk(o_bubble, 0);
    i_grp_pred_tkn = 4'h0;
    i_grp_valid = 4'h1;
    i_grp_class[0] = pac_pkg::CLS_INT_ADD;
    tick();
    for (int i = 0; i < 24; i++) begin
      tick();
      {i_reg_conflict, i_fu_conflict, i_dc_miss} = 3'(1 << ($random(seed) & 3));
      i_stage_occ = 4'($random(seed));
      st = i_reg_conflict | i_fu_conflict | i_dc_miss;
      #1;
      chk(o_issue_stall, st);
      chk(o_stage_adv, {!st, ~i_stage_occ[3:1] | {3{!st}}});
    end
    {i_reg_conflict, i_fu_conflict, i_dc_miss, i_grp_valid} = '0;
    for (int i = 0; i < 12; i++) begin
      tick();
      s = $random(seed) & 3;
      pc = {$random(seed), $random(seed)};
      {i_mispredict, i_rsrc_replay, i_dc_miss} = 3'(4 >> (i % 3));
      i_dc_use_issued = i_dc_miss;
      {i_mispredict_slot, i_rsrc_slot, i_dc_use_slot} = {3{s[1:0]}};
      {i_mispredict_pc, i_rsrc_pc, i_dc_use_pc} = {3{pc}};
      tick();
      {i_mispredict, i_rsrc_replay, i_dc_miss, i_dc_use_issued} = '0;
      chk(o_redirect, 1);
      chk(o_redirect_pc, pc);
      chk(o_kill_mask, kmask(s, i % 3 != 0));
      chk(o_flush, 1);
    end
    for (int i = 0; i < 9; i++) begin
      tick();
      s = $random(seed) & 3;
      lag = 4'($random(seed) & 7);
      pc = {$random(seed), $random(seed)};
      i_exc = 1'b1;
      i_exc_kind = pac_pkg::pac_exc_e'(i % 3);
      i_exc_slot = s[1:0];
      // The dispatch address stays put for the whole drain, whichever cycle samples it.
      {i_exc_fault_pc, i_exc_next_pc, i_fw_dispatch_pc} = {pc, pc + 64'h4, ~pc};
      tick();
      i_exc = 1'b0;
      chk(o_exception_address_register, (i % 3 == 2) ? pc : pc + 64'h4);
      chk(o_kill_mask, (i % 3 == 0) ? 4'h0 : kmask(s, 1));
      chk(o_wb_suppress, i % 3 != 0);
      for (int j = 0; j < 40 && o_redirect !== 1'b1; j++) tick();
      chk(o_redirect, 1);
      chk(o_redirect_pc, ~pc);
    end
    complete_run();
  end
endmodule : tb_pac_abort_ctl
`default_nettype wire
